// file: cdh_deglitch.sv
// Persistence filter for one power-sense input
`timescale 1ns/10ps
module cdh_deglitch #(
    parameter int UNIT_CYCLES = 12,
    parameter int TIME_W = 7
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // Control
    input wire logic i_bypass,
    input wire logic [TIME_W-1:0] i_time,
    // Sense in, filtered out
    input wire logic i_sense,
    output logic o_filtered
);
    import cdh_pkg::*;

    localparam int CYC_W = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(UNIT_CYCLES - 1);

    generate
        if (UNIT_CYCLES < 1 || TIME_W < 1) begin : g_bad
            $error("cdh_deglitch: UNIT_CYCLES and TIME_W must be >= 1");
        end
    endgenerate

    cdh_filt_state_t state_reg, state_next;
    logic [CYC_W-1:0] cyc_reg, cyc_next;
    logic [TIME_W-1:0] unit_reg, unit_next;
    logic prev_reg, prev_next;
    logic filt_reg, filt_next;
    logic changed;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        changed = i_sense != prev_reg;
        state_next = state_reg;
        cyc_next = cyc_reg;
        unit_next = unit_reg;
        prev_next = i_sense;
        if (changed) begin
            // Any edge drops the output when not bypassed and restarts the wait
            cyc_next = '0;
            unit_next = '0;
            state_next = i_sense ? CDH_FILT_COUNT : CDH_FILT_LOW;
        end else begin
            case (state_reg)
                CDH_FILT_LOW: begin
                    if (i_sense) begin
                        state_next = CDH_FILT_COUNT;
                        cyc_next = '0;
                        unit_next = '0;
                    end
                end
                CDH_FILT_COUNT: begin
                    // One unit is UNIT_CYCLES reference clock cycles
                    if (unit_reg == i_time) begin
                        state_next = CDH_FILT_HIGH;
                    end else if (cyc_reg == CYC_LAST) begin
                        cyc_next = '0;
                        unit_next = unit_reg + 1'b1;
                    end else begin
                        cyc_next = cyc_reg + 1'b1;
                    end
                end
                CDH_FILT_HIGH: begin
                    state_next = CDH_FILT_HIGH;
                end
                default: begin
                    state_next = CDH_FILT_LOW;
                end
            endcase
        end
        // Bypass passes the sense level straight through
        filt_next = i_bypass ? i_sense : (state_next == CDH_FILT_HIGH);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            state_reg <= CDH_FILT_LOW;
            cyc_reg <= '0;
            unit_reg <= '0;
            prev_reg <= 1'b0;
            filt_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            unit_reg <= unit_next;
            prev_reg <= prev_next;
            filt_reg <= filt_next;
        end
    end

    assign o_filtered = filt_reg;

endmodule // cdh_deglitch

// file: cdh_hotplug_top.sv
// Cable detect filtering, receiver reset and hot plug control
`timescale 1ns/10ps
`include "cdh_params.svh"
module cdh_hotplug_top #(
    parameter int STEP_CYCLES = `CDH_DELAY_STEP_CYCLES,
    parameter int UNIT_CYCLES = `CDH_DEGLITCH_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Power-sense pins and identification enables
    input wire logic i_port_a_power_sense,
    input wire logic i_port_b_power_sense,
    input wire logic i_id_active_a,
    input wire logic i_id_active_b,
    input wire logic i_port_sel_b,
    // Hot plug open-drain pins
    output logic o_hotplug_out_a_o,
    output logic o_hotplug_out_a_oe,
    output logic o_hotplug_out_b_o,
    output logic o_hotplug_out_b_oe,
    // Status
    output logic o_cable_present_filt_a,
    output logic o_cable_present_filt_b,
    output logic o_rx_section_reset
);
    import cdh_pkg::*;

    // Step counter wide enough for one whole delay step
    localparam int STEP_W = $clog2(STEP_CYCLES + 1);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

    // Refuse counts that would leave a counter with no cycles
    generate
        if (STEP_CYCLES < 1 || UNIT_CYCLES < 1) begin : g_bad
            $error("cdh_hotplug_top: cycle counts must be >= 1");
        end
    endgenerate

    // ------------------------------------------------------------
    // Decision for one port
    // ------------------------------------------------------------
    function automatic logic hp_decide(
        input logic override_en,
        input cdh_policy_t policy,
        input logic forced,
        input logic id_active,
        input logic delayed
    );
        logic res;
        res = 1'b0;
        // Override wins over every automatic policy
        if (override_en) begin
            res = forced;
        end else begin
            case (policy)
                CDH_POL_ID: res = id_active;
                CDH_POL_CABLE: res = delayed;
                CDH_POL_ID_RAW: res = id_active & delayed;
                CDH_POL_ID_RAW_FORCED: begin
                    res = id_active & delayed & forced;
                end
                default: res = 1'b0;
            endcase
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Per-port pairs: bit 0 is port A, bit 1 is port B
    logic [1:0] forced_reg, forced_next;
    logic inhibit_reg, inhibit_next;
    logic bypass_reg, bypass_next;
    logic [6:0] time_reg, time_next;
    logic override_reg, override_next;
    cdh_policy_t policy_reg, policy_next;
    logic [3:0] delay_reg, delay_next;
    logic [7:0] rdata_reg, rdata_next;

    logic [1:0] sense;
    logic [1:0] id_active;
    logic [1:0] filt;
    logic [1:0] hp_assert;

    assign sense = {i_port_b_power_sense, i_port_a_power_sense};
    assign id_active = {i_id_active_b, i_id_active_a};

    always_comb begin
        forced_next = forced_reg;
        inhibit_next = inhibit_reg;
        bypass_next = bypass_reg;
        time_next = time_reg;
        override_next = override_reg;
        policy_next = policy_reg;
        delay_next = delay_reg;

        // Writes land at the edge that samples the strobe
        if (i_reg_wr) begin
            case (i_reg_addr)
                `CDH_ADDR_FORCED: begin
                    forced_next[0] = i_reg_wdata[`CDH_BIT_FORCED_A];
                    forced_next[1] = i_reg_wdata[`CDH_BIT_FORCED_B];
                end
                `CDH_ADDR_INHIBIT: begin
                    inhibit_next = i_reg_wdata[`CDH_BIT_INHIBIT];
                end
                `CDH_ADDR_DEGLITCH: begin
                    bypass_next = i_reg_wdata[`CDH_BIT_BYPASS];
                    time_next = i_reg_wdata[`CDH_MSB_TIME:`CDH_LSB_TIME];
                end
                // Override, policy and delay share one register
                `CDH_ADDR_HP_CTRL: begin
                    override_next = i_reg_wdata[`CDH_BIT_OVERRIDE];
                    policy_next = cdh_policy_t'(
                        i_reg_wdata[`CDH_MSB_POLICY:`CDH_LSB_POLICY]);
                    delay_next = i_reg_wdata[`CDH_MSB_DELAY:`CDH_LSB_DELAY];
                end
                default: begin
                end
            endcase
        end

        // Read data, unmapped offsets and reserved bits read zero
        rdata_next = 8'h00;
        case (i_reg_addr)
            `CDH_ADDR_FORCED: begin
                rdata_next[`CDH_BIT_FORCED_A] = forced_reg[0];
                rdata_next[`CDH_BIT_FORCED_B] = forced_reg[1];
            end
            `CDH_ADDR_HP_STATUS: begin
                rdata_next[`CDH_BIT_HP_STATUS_A] = hp_assert[0];
                rdata_next[`CDH_BIT_HP_STATUS_B] = hp_assert[1];
            end
            `CDH_ADDR_INHIBIT: rdata_next[`CDH_BIT_INHIBIT] = inhibit_reg;
            `CDH_ADDR_DEGLITCH: begin
                rdata_next[`CDH_BIT_BYPASS] = bypass_reg;
                rdata_next[`CDH_MSB_TIME:`CDH_LSB_TIME] = time_reg;
            end
            `CDH_ADDR_HP_CTRL: begin
                rdata_next[`CDH_BIT_OVERRIDE] = override_reg;
                rdata_next[`CDH_MSB_POLICY:`CDH_LSB_POLICY] = policy_reg;
                rdata_next[`CDH_MSB_DELAY:`CDH_LSB_DELAY] = delay_reg;
            end
            // Raw detect bits read the pin level, unfiltered
            `CDH_ADDR_RAW_A: rdata_next[`CDH_BIT_RAW_A] = sense[0];
            `CDH_ADDR_RAW_B: rdata_next[`CDH_BIT_RAW_B] = sense[1];
            default: rdata_next = 8'h00;
        endcase
    end

    // Reset values follow the register map
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            forced_reg <= {2{`CDH_RST_FORCED}};
            inhibit_reg <= `CDH_RST_INHIBIT;
            bypass_reg <= `CDH_RST_BYPASS;
            time_reg <= `CDH_RST_TIME;
            override_reg <= `CDH_RST_OVERRIDE;
            policy_reg <= cdh_policy_t'(`CDH_RST_POLICY);
            delay_reg <= `CDH_RST_DELAY;
            rdata_reg <= 8'h00;
        end else begin
            forced_reg <= forced_next;
            inhibit_reg <= inhibit_next;
            bypass_reg <= bypass_next;
            time_reg <= time_next;
            override_reg <= override_next;
            policy_reg <= policy_next;
            delay_reg <= delay_next;
            rdata_reg <= rdata_next;
        end
    end

    // Read data follows the address one cycle late
    assign o_reg_rdata = rdata_reg;

    // ------------------------------------------------------------
    // Per-port filter, delay and decision
    // ------------------------------------------------------------
    // One filter, delay counter and decision per port
    generate
        for (genvar p = 0; p < 2; p++) begin : g_port
            // Step counter, whole steps elapsed and decision
            logic [STEP_W-1:0] cyc_reg, cyc_next;
            logic [3:0] steps_reg, steps_next;
            logic hp_reg, hp_next;
            logic src;
            logic delayed;

            // Counted in reference clocks so timing holds in any mode
            cdh_deglitch #(
                .UNIT_CYCLES(UNIT_CYCLES),
                .TIME_W(7)
            ) u_deglitch (
                .i_ref_clk(i_ref_clk),
                .i_resetn(i_resetn),
                .i_bypass(bypass_reg),
                .i_time(time_reg),
                .i_sense(sense[p]),
                .o_filtered(filt[p])
            );

            always_comb begin
                // Policy 01 waits on the filtered detect, others on raw
                src = (policy_reg == CDH_POL_CABLE) ? filt[p] : sense[p];
                cyc_next = cyc_reg;
                steps_next = steps_reg;
                if (!src) begin
                    cyc_next = '0;
                    steps_next = '0;
                end else if (steps_reg < delay_reg) begin
                    if (cyc_reg == STEP_LAST) begin
                        cyc_next = '0;
                        steps_next = steps_reg + 1'b1;
                    end else begin
                        cyc_next = cyc_reg + 1'b1;
                    end
                end

                // Delay met only while the source still stands high
                delayed = src && (steps_reg >= delay_reg);
                // Decided every cycle; the pin follows at the next edge
                hp_next = hp_decide(override_reg, policy_reg, forced_reg[p],
                                    id_active[p], delayed);
            end

            // Counters and decision register together
            always_ff @(posedge i_ref_clk) begin
                if (!i_resetn) begin
                    cyc_reg <= '0;
                    steps_reg <= '0;
                    hp_reg <= 1'b0;
                end else begin
                    cyc_reg <= cyc_next;
                    steps_reg <= steps_next;
                    hp_reg <= hp_next;
                end
            end

            assign hp_assert[p] = hp_reg;
        end
    endgenerate

    // ------------------------------------------------------------
    // Pins and receiver reset
    // ------------------------------------------------------------
    // Receiver reset follows the selected port only
    logic rx_rst_reg, rx_rst_next;

    always_comb begin
        // Selected port's filtered sense gates the receiver
        rx_rst_next = !inhibit_reg &&
                      !(i_port_sel_b ? filt[1] : filt[0]);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            rx_rst_reg <= 1'b0;
        end else begin
            rx_rst_reg <= rx_rst_next;
        end
    end

    // Drive only low; the external pull-up makes the high level
    assign o_hotplug_out_a_o = 1'b0;
    assign o_hotplug_out_b_o = 1'b0;
    assign o_hotplug_out_a_oe = !hp_assert[0];
    assign o_hotplug_out_b_oe = !hp_assert[1];

    // Status straight from the filters and the reset register
    assign o_cable_present_filt_a = filt[0];
    assign o_cable_present_filt_b = filt[1];
    assign o_rx_section_reset = rx_rst_reg;

endmodule // cdh_hotplug_top

// file: cdh_hotplug_top_asserts.sv
// Port checker for the cable detect and hot plug block
`timescale 1ns/10ps
module cdh_hotplug_top_asserts #(
    parameter int STEP_CYCLES = 10,
    parameter int UNIT_CYCLES = 2
) (
    // Clock, reset and register port
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    // Sense and selection
    input wire logic i_port_a_power_sense,
    input wire logic i_id_active_a,
    input wire logic i_port_sel_b,
    // Outputs watched
    input wire logic o_hotplug_out_a_o,
    input wire logic o_hotplug_out_a_oe,
    input wire logic o_hotplug_out_b_o,
    input wire logic o_hotplug_out_b_oe,
    input wire logic o_cable_present_filt_a,
    input wire logic o_cable_present_filt_b,
    input wire logic o_rx_section_reset
);
    logic [1:0] frc_reg, frc_next;
    logic inh_reg, inh_next;
    logic [7:0] dg_reg, dg_next;
    logic [6:0] hc_reg, hc_next;
    logic [31:0] sc_reg, sc_next, fc_reg, fc_next;
    logic ovr, sel_filt;
    logic [1:0] pol;
    logic [3:0] dly;
    assign ovr = hc_reg[0];
    assign pol = hc_reg[2:1];
    assign dly = hc_reg[6:3];
    assign sel_filt = i_port_sel_b ? o_cable_present_filt_b
                                   : o_cable_present_filt_a;
    // --------------------------------------------------------
    // Register mirror and run-length counters
    // --------------------------------------------------------
    always_comb begin
        frc_next = frc_reg;
        inh_next = inh_reg;
        dg_next = dg_reg;
        hc_next = hc_reg;
        if (i_reg_wr) begin
            case (i_reg_addr)
                8'h20: frc_next = i_reg_wdata[7:6];
                8'h48: inh_next = i_reg_wdata[6];
                8'h56: dg_next = i_reg_wdata;
                8'h6C: hc_next = {i_reg_wdata[7:4], i_reg_wdata[2:0]};
                default: ;
            endcase
        end
        sc_next = i_port_a_power_sense ? sc_reg + 32'h0000_0001 : '0;
        fc_next = o_cable_present_filt_a ? fc_reg + 32'h0000_0001 : '0;
    end
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            frc_reg <= 2'h3;
            inh_reg <= 1'b0;
            dg_reg <= 8'h58;
            hc_reg <= 7'h52;
            sc_reg <= 32'h0000_0000;
            fc_reg <= 32'h0000_0000;
        end else begin
            frc_reg <= frc_next;
            inh_reg <= inh_next;
            dg_reg <= dg_next;
            hc_reg <= hc_next;
            sc_reg <= sc_next;
            fc_reg <= fc_next;
        end
    end
    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    property p_od_data;
        !o_hotplug_out_a_o && !o_hotplug_out_b_o;
    endproperty
    a_od_data: assert property (p_od_data)
        else $error("hot plug data not low");
    property p_man;
        ovr |=> ({o_hotplug_out_a_oe, o_hotplug_out_b_oe} == ~$past(frc_reg));
    endproperty
    a_man: assert property (p_man)
        else $error("override level wrong");
    property p_pol0;
        (!ovr && pol == 2'h0) |=>
            (o_hotplug_out_a_oe == !$past(i_id_active_a));
    endproperty
    a_pol0: assert property (p_pol0)
        else $error("policy 0 level wrong");
    property p_pol1_off;
        (!ovr && pol == 2'h1 && !o_cable_present_filt_a) |->
            ##[1:2] o_hotplug_out_a_oe;
    endproperty
    a_pol1_off: assert property (p_pol1_off)
        else $error("policy 1 late release");
    property p_pol1_on;
        (!ovr && pol == 2'h1 && $fell(o_hotplug_out_a_oe)) |->
            (fc_reg >= dly * STEP_CYCLES);
    endproperty
    a_pol1_on: assert property (p_pol1_on)
        else $error("policy 1 early assert");
    property p_pol23_off;
        (!ovr && pol[1] && (!i_id_active_a || !i_port_a_power_sense ||
            (pol[0] && !frc_reg[1]))) |-> ##[1:3] o_hotplug_out_a_oe;
    endproperty
    a_pol23_off: assert property (p_pol23_off)
        else $error("policy 2 or 3 late release");
    property p_rx;
        1'b1 |=> (o_rx_section_reset == $past(!inh_reg && !sel_filt));
    endproperty
    a_rx: assert property (p_rx)
        else $error("receiver reset wrong");
    property p_chg;
        (!dg_reg[7] && $changed(i_port_a_power_sense)) |->
            ##[1:2] !o_cable_present_filt_a;
    endproperty
    a_chg: assert property (p_chg)
        else $error("filter kept high on change");
    property p_persist;
        (!dg_reg[7] && $rose(o_cable_present_filt_a)) |->
            (sc_reg >= dg_reg[6:0] * UNIT_CYCLES);
    endproperty
    a_persist: assert property (p_persist)
        else $error("filter rose too early");
    c_hp_rise: cover property (!ovr && $fell(o_hotplug_out_a_oe));
    c_filt: cover property ($rose(o_cable_present_filt_a));
    c_rx: cover property ($fell(o_rx_section_reset));
endmodule // cdh_hotplug_top_asserts

bind cdh_hotplug_top cdh_hotplug_top_asserts #(
    .STEP_CYCLES(STEP_CYCLES),
    .UNIT_CYCLES(UNIT_CYCLES)
) chk_u (.i_ref_clk, .i_resetn, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
    .i_port_a_power_sense, .i_id_active_a, .i_port_sel_b,
    .o_hotplug_out_a_o, .o_hotplug_out_a_oe, .o_hotplug_out_b_o,
    .o_hotplug_out_b_oe, .o_cable_present_filt_a, .o_cable_present_filt_b,
    .o_rx_section_reset);

// file: cdh_hotplug_top_tb.sv
// Self-checking bench for the cable detect and hot plug block
`timescale 1ns/10ps
module cdh_hotplug_top_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic plug_a = 1'b0;
    logic plug_b = 1'b0;
    logic id_a = 1'b0;
    logic id_b = 1'b0;
    logic sel_b = 1'b0;
    logic [7:0] rdata;
    logic sense_a, sense_b, hp_a, hp_b, o_a, oe_a, o_b, oe_b;
    logic filt_a, filt_b, rx_rst;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    cdh_hotplug_top #(.STEP_CYCLES(10), .UNIT_CYCLES(2)) dut_u (
        .i_ref_clk(clk), .i_resetn(rstn), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_port_a_power_sense(sense_a), .i_port_b_power_sense(sense_b),
        .i_id_active_a(id_a), .i_id_active_b(id_b), .i_port_sel_b(sel_b),
        .o_hotplug_out_a_o(o_a), .o_hotplug_out_a_oe(oe_a),
        .o_hotplug_out_b_o(o_b), .o_hotplug_out_b_oe(oe_b),
        .o_cable_present_filt_a(filt_a), .o_cable_present_filt_b(filt_b),
        .o_rx_section_reset(rx_rst));
    cdh_source_model src_a (.i_plug(plug_a), .i_hp_o(o_a), .i_hp_oe(oe_a),
        .o_power_sense(sense_a), .o_hp_level(hp_a));
    cdh_source_model src_b (.i_plug(plug_b), .i_hp_o(o_b), .i_hp_oe(oe_b),
        .o_power_sense(sense_b), .o_hp_level(hp_b));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            $display("ERROR %0t: run timed out", $time);
            wrap_up();
        end
    end
    // --------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------
    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic expect1(input logic got, input logic exp);
        expect8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                          input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        expect8(rdata & m, e);
    endtask
    task automatic wait_hp(input logic lvl, input int lim);
        int n;
        n = 0;
        while (hp_a !== lvl && n < lim) begin
            @(negedge clk);
            n = n + 1;
        end
        expect1(hp_a, lvl);
    endtask
    // --------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------
    task automatic t_reset();
        rd_chk(8'h20, 8'hC0, 8'hC0);
        rd_chk(8'h48, 8'h40, 8'h00);
        rd_chk(8'h56, 8'hFF, 8'h58);
        rd_chk(8'h6C, 8'hF7, 8'hA2);
        rd_chk(8'h7F, 8'hFF, 8'h00);
        expect1(rx_rst, 1'b1);
    endtask
    task automatic t_filter();
        wr_reg(8'h56, 8'h05);
        plug_a = 1'b1;
        idle(9);
        expect1(filt_a, 1'b0);
        plug_a = 1'b0;
        idle(1);
        plug_a = 1'b1;
        idle(9);
        expect1(filt_a, 1'b0);
        idle(12);
        expect1(filt_a, 1'b1);
        expect1(rx_rst, 1'b0);
        rd_chk(8'h6F, 8'h01, 8'h01);
    endtask
    task automatic t_delay();
        idle(80);
        expect1(hp_a, 1'b0);
        wait_hp(1'b1, 30);
        plug_a = 1'b0;
        wait_hp(1'b0, 3);
        plug_a = 1'b1;
        idle(60);
        plug_a = 1'b0;
        idle(2);
        plug_a = 1'b1;
        idle(95);
        expect1(hp_a, 1'b0);
        wait_hp(1'b1, 40);
    endtask
    task automatic t_override();
        wr_reg(8'h20, 8'h40);
        wr_reg(8'h6C, 8'h01);
        id_a = 1'b1;
        idle(3);
        expect1(hp_a, 1'b0);
        expect1(hp_b, 1'b1);
        wr_reg(8'h20, 8'h80);
        idle(3);
        expect1(hp_a, 1'b1);
        expect1(hp_b, 1'b0);
        rd_chk(8'h21, 8'h0C, 8'h08);
    endtask
    task automatic t_auto();
        id_a = 1'b0;
        wr_reg(8'h6C, 8'h00);
        wait_hp(1'b0, 3);
        id_a = 1'b1;
        wait_hp(1'b1, 3);
        id_a = 1'b0;
        wait_hp(1'b0, 3);
        wr_reg(8'h6C, 8'h14);
        id_a = 1'b1;
        wait_hp(1'b1, 20);
        plug_a = 1'b0;
        wait_hp(1'b0, 4);
        plug_a = 1'b1;
        idle(5);
        expect1(hp_a, 1'b0);
        wait_hp(1'b1, 15);
        wr_reg(8'h6C, 8'h16);
        wr_reg(8'h20, 8'h40);
        wait_hp(1'b0, 4);
        wr_reg(8'h20, 8'hC0);
        wait_hp(1'b1, 20);
        id_a = 1'b0;
        wait_hp(1'b0, 4);
    endtask
    task automatic t_inhibit();
        plug_a = 1'b0;
        idle(4);
        expect1(rx_rst, 1'b1);
        wr_reg(8'h48, 8'h40);
        idle(2);
        expect1(rx_rst, 1'b0);
        wr_reg(8'h48, 8'h00);
        sel_b = 1'b1;
        id_b = 1'b1;
        plug_b = 1'b1;
        idle(25);
        expect1(rx_rst, 1'b0);
        expect1(filt_b, 1'b1);
        rd_chk(8'h6A, 8'h80, 8'h80);
        wr_reg(8'h56, 8'h85);
        plug_a = 1'b1;
        idle(1);
        expect1(filt_a, 1'b1);
        plug_a = 1'b0;
        idle(1);
        expect1(filt_a, 1'b0);
    endtask

    initial begin
        idle(2);
        rstn = 1'b1;
        t_reset();
        t_filter();
        t_delay();
        t_override();
        t_auto();
        t_inhibit();
        wrap_up();
    end
endmodule // cdh_hotplug_top_tb

// file: cdh_params.svh
// Register map, field positions, reset values and timing counts
`ifndef CDH_PARAMS_SVH
`define CDH_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CDH_ADDR_FORCED 8'h20
`define CDH_ADDR_HP_STATUS 8'h21
`define CDH_ADDR_INHIBIT 8'h48
`define CDH_ADDR_DEGLITCH 8'h56
`define CDH_ADDR_RAW_B 8'h6A
`define CDH_ADDR_HP_CTRL 8'h6C
`define CDH_ADDR_RAW_A 8'h6F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CDH_BIT_FORCED_A 7
`define CDH_BIT_FORCED_B 6
`define CDH_BIT_HP_STATUS_A 3
`define CDH_BIT_HP_STATUS_B 2
`define CDH_BIT_INHIBIT 6
`define CDH_BIT_BYPASS 7
`define CDH_LSB_TIME 0
`define CDH_MSB_TIME 6
`define CDH_LSB_DELAY 4
`define CDH_MSB_DELAY 7
`define CDH_LSB_POLICY 1
`define CDH_MSB_POLICY 2
`define CDH_BIT_OVERRIDE 0
`define CDH_BIT_RAW_A 0
`define CDH_BIT_RAW_B 7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CDH_RST_FORCED 1'b1
`define CDH_RST_INHIBIT 1'b0
`define CDH_RST_BYPASS 1'b0
`define CDH_RST_TIME 7'h58
`define CDH_RST_OVERRIDE 1'b0
`define CDH_RST_POLICY 2'h1
`define CDH_RST_DELAY 4'hA

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CDH_CLK_PERIOD_NS 4
`define CDH_DEGLITCH_UNIT_NS 47
`define CDH_DEGLITCH_UNIT_CYCLES \
    ((`CDH_DEGLITCH_UNIT_NS + `CDH_CLK_PERIOD_NS - 1) / `CDH_CLK_PERIOD_NS)
`define CDH_DELAY_STEP_MS 100
`define CDH_DELAY_STEP_CYCLES \
    ((`CDH_DELAY_STEP_MS * 1000000) / `CDH_CLK_PERIOD_NS)

`endif

// file: cdh_pkg.sv
// Types shared by the cable detect and hot plug logic
package cdh_pkg;

    typedef enum logic [1:0] {
        CDH_POL_ID = 2'h0,
        CDH_POL_CABLE = 2'h1,
        CDH_POL_ID_RAW = 2'h2,
        CDH_POL_ID_RAW_FORCED = 2'h3
    } cdh_policy_t;

    typedef enum logic [2:0] {
        CDH_FILT_LOW = 3'b001,
        CDH_FILT_COUNT = 3'b010,
        CDH_FILT_HIGH = 3'b100
    } cdh_filt_state_t;

endpackage

// file: cdh_source_model.sv
// Video source model: drives power sense and sees the hot plug line
`timescale 1ns/10ps
module cdh_source_model (
    // Cable plug control and receiver open-drain pin
    input wire logic i_plug,
    input wire logic i_hp_o,
    input wire logic i_hp_oe,
    // Sense drive and line level seen by the source
    output logic o_power_sense,
    output logic o_hp_level
);
    assign o_power_sense = i_plug;
    // Pull-up holds the line high unless the receiver pulls it down
    assign o_hp_level = i_hp_oe ? i_hp_o : 1'b1;
endmodule // cdh_source_model
